// ===== pkg/acrs_pkg.sv
// Register map, field positions and timing constants of the clock/reference block
package acrs_pkg;
  // Register indices; byte address is four times the index
  localparam logic [7:0]  IDX_MODE      = 8'h01;
  localparam logic [7:0]  IDX_SETUP0    = 8'h20;
  localparam logic [7:0]  IDX_STATUS    = 8'h03;
  localparam logic [9:0]  ADDR_MODE     = {IDX_MODE, 2'b00};
  localparam logic [9:0]  ADDR_SETUP0   = {IDX_SETUP0, 2'b00};
  localparam logic [9:0]  ADDR_STATUS   = {IDX_STATUS, 2'b00};
  // Reset values and writable bits
  localparam logic [15:0] MODE_RST      = 16'h2000;
  localparam logic [15:0] MODE_MASK     = 16'hA77C;
  localparam logic [15:0] SETUP0_RST    = 16'h1000;
  localparam logic [15:0] SETUP0_MASK   = 16'h1FF0;
  // Field positions
  localparam int          MODE_REFEN    = 15;
  localparam int          MODE_SCYC     = 13;
  localparam int          MODE_CSEL_LO  = 2;
  localparam int          SET_BIPOL     = 12;
  localparam int          SET_REFBUF_LO = 10;
  localparam int          SET_AINBUF_LO = 8;
  localparam int          SET_BURNOUT   = 7;
  localparam int          SET_CHOPMAX   = 6;
  localparam int          SET_REFSEL_LO = 4;
  // Reference selections
  localparam logic [1:0]  REFSEL_EXT    = 2'h0;
  // Timing: internal oscillator derived from ref_clk
  localparam int          REF_CLK_MHZ   = 250;
  localparam int          MCLK_MHZ      = 2;
  localparam int          OSC_DIV       = REF_CLK_MHZ / MCLK_MHZ;
  localparam int          OSC_HIGH      = OSC_DIV / 2;
  localparam int          XTAL_DIV      = 8;
  localparam int          XTAL_HALF     = XTAL_DIV / 2;
  // Clock sources
  typedef enum logic [1:0]
  {
    SRC_INT     = 2'b00,
    SRC_INT_OUT = 2'b01,
    SRC_EXT     = 2'b10,
    SRC_XTAL    = 2'b11
  } acrs_src_t;
endpackage

// ===== hw/acrs_top.sv
// Master clock source selection and reference control with AHB-Lite registers
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
// Summary of operation
// - Per-setup two-bit field picks reference; external reference after reset.
// - Internal reference is off after reset; on when enable bit written one.
// - Enable bit set drives buffered 2.5 V reference onto reference output.
// - Converter core runs from 2 MHz master clock for internal and crystal sources; external source sets its own rate.
// - Mode register field selects clock source; internal oscillator after reset.
// - Crystal source: 16 MHz crystal divided internally to 2 MHz.
// - External source: clock enters shared pin and is routed to modulator.
// - Option drives internal oscillator clock out on shared clock pin.
// - Output rates scale with master clock frequency.
// - Max-chop bit of active setup raises input buffer chop rate.
module acrs_top
  import acrs_pkg::*;
(
  // Clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Clock pins
  input  wire logic        crystalIn,
  input  wire logic        sharedClkIn,
  output logic             sharedClkOut,
  output logic             sharedClkOe_n,
  // Converter core controls
  output logic             masterClk,
  output logic             modulatorTick,
  output logic             refOutEnable,
  output logic [1:0]       refSelect,
  output logic             bufChopMax,
  output logic             singleCycle,
  output logic [1:0]       ainBufEnable,
  output logic [1:0]       refBufEnable,
  output logic             bipolar,
  output logic             burnoutEnable
);

  logic [1:0]  rstSync;
  logic        rstN;
  logic [15:0] modeReg;
  logic [15:0] setupReg;
  logic        wrPend;
  logic [9:0]  wrAddr;
  logic [1:0]  xtalSync;
  logic [1:0]  extSync;
  logic        xtalPrev;
  logic [1:0]  xtalCnt;
  logic        xtalDiv;
  logic [6:0]  oscCnt;
  logic        intClk;
  acrs_src_t   activeSrc;

  // Reset release through two flops
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      rstSync <= 2'b00;
    else
      rstSync <= {rstSync[0], 1'b1};
  end
  assign rstN = rstSync[1];

  // Bus decode
  wire        addrPhase   = hsel && htrans[1] && hready;
  wire        hitMode     = wrAddr == ADDR_MODE;
  wire        hitSetup    = wrAddr == ADDR_SETUP0;
  wire [15:0] next_mode   = (wrPend && hitMode)
                            ? (hwdata[15:0] & MODE_MASK) : modeReg;
  wire [15:0] next_setup  = (wrPend && hitSetup)
                            ? (hwdata[15:0] & SETUP0_MASK) : setupReg;
  wire        isPending   = acrs_src_t'(modeReg[MODE_CSEL_LO +: 2])
                            != activeSrc;
  wire [15:0] statusWord  = {12'h000, isPending, masterClk, activeSrc};
  wire [9:0]  rdAddr      = haddr[9:0];
  wire [15:0] readMux;

  // Reads see a write still in its data phase
  assign readMux = (haddr[31:10] != 22'h000000) ? 16'h0000 :
                   (rdAddr == ADDR_MODE)   ? next_mode :
                   (rdAddr == ADDR_SETUP0) ? next_setup :
                   (rdAddr == ADDR_STATUS) ? statusWord : 16'h0000;

  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      wrPend    <= 1'b0;
      wrAddr    <= 10'h000;
      hrdata    <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
    else
    begin
      wrPend    <= addrPhase && hwrite && (haddr[31:10] == 22'h000000);
      wrAddr    <= haddr[9:0];
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      if (addrPhase && !hwrite)
        hrdata <= {16'h0000, readMux};
    end
  end

  // Register file
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      modeReg  <= MODE_RST;
      setupReg <= SETUP0_RST;
    end
    else
    begin
      modeReg  <= next_mode;
      setupReg <= next_setup;
    end
  end

  // Static controls towards the converter core
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      refOutEnable  <= 1'b0;
      refSelect     <= REFSEL_EXT;
      bufChopMax    <= 1'b0;
      singleCycle   <= 1'b1;
      ainBufEnable  <= 2'b00;
      refBufEnable  <= 2'b00;
      bipolar       <= 1'b1;
      burnoutEnable <= 1'b0;
    end
    else
    begin
      refOutEnable  <= modeReg[MODE_REFEN];
      refSelect     <= setupReg[SET_REFSEL_LO +: 2];
      bufChopMax    <= setupReg[SET_CHOPMAX];
      singleCycle   <= modeReg[MODE_SCYC];
      ainBufEnable  <= setupReg[SET_AINBUF_LO +: 2];
      refBufEnable  <= setupReg[SET_REFBUF_LO +: 2];
      bipolar       <= setupReg[SET_BIPOL];
      burnoutEnable <= setupReg[SET_BURNOUT];
    end
  end

  // Pin synchronisers; only stage one reads stage zero
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      xtalSync <= 2'b00;
      extSync  <= 2'b00;
      xtalPrev <= 1'b0;
    end
    else
    begin
      xtalSync <= {xtalSync[0], crystalIn};
      extSync  <= {extSync[0], sharedClkIn};
      xtalPrev <= xtalSync[1];
    end
  end

  // Internal oscillator: ref_clk divided to 2 MHz
  wire oscWrap = oscCnt == 7'(OSC_DIV - 1);
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      oscCnt <= 7'h00;
      intClk <= 1'b0;
    end
    else
    begin
      oscCnt <= oscWrap ? 7'h00 : oscCnt + 7'h01;
      intClk <= oscCnt < 7'(OSC_HIGH);
    end
  end

  // Crystal: half period is four crystal rising edges
  wire xtalRise = xtalSync[1] && !xtalPrev;
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      xtalCnt <= 2'b00;
      xtalDiv <= 1'b0;
    end
    else if (activeSrc != SRC_XTAL)
    begin
      xtalCnt <= 2'b00;
      xtalDiv <= 1'b0;
    end
    else if (xtalRise)
    begin
      xtalCnt <= xtalCnt + 2'b01;
      if (xtalCnt == 2'(XTAL_HALF - 1))
        xtalDiv <= !xtalDiv;
    end
  end

  // Glitch-free source switch: hand over only while master clock is low
  wire acrs_src_t reqSrc = acrs_src_t'(modeReg[MODE_CSEL_LO +: 2]);
  wire selLevel = (activeSrc == SRC_EXT)  ? extSync[1] :
                  (activeSrc == SRC_XTAL) ? xtalDiv : intClk;
  wire reqLevel = (reqSrc == SRC_EXT)  ? extSync[1] :
                  (reqSrc == SRC_XTAL) ? 1'b0 : intClk;
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      activeSrc     <= SRC_INT;
      masterClk     <= 1'b0;
      modulatorTick <= 1'b0;
    end
    else
    begin
      if (isPending && !masterClk && !reqLevel)
        activeSrc <= reqSrc;
      // A pending switch lets a high phase finish, then parks the clock low
      masterClk     <= isPending ? (masterClk && selLevel)
                                 : selLevel;
      modulatorTick <= !isPending && selLevel && !masterClk;
    end
  end

  // Shared pin drives oscillator clock only in the output option
  always_ff @(posedge ref_clk or negedge rstN)
  begin
    if (!rstN)
    begin
      sharedClkOut  <= 1'b0;
      sharedClkOe_n <= 1'b1;
    end
    else
    begin
      sharedClkOut  <= intClk;
      sharedClkOe_n <= activeSrc != SRC_INT_OUT;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstN);

  a_reference_output_pin_follow: assert property (
    modeReg[MODE_REFEN] |=> refOutEnable)
    else $error("reference output not enabled");
  a_refsel_follow: assert property (
    ##1 refSelect == $past(setupReg[SET_REFSEL_LO +: 2]))
    else $error("reference select mismatch");
  a_chop_follow: assert property (
    $rose(setupReg[SET_CHOPMAX]) |=> bufChopMax)
    else $error("chop max not applied");
  a_mode_write: assert property (
    wrPend && hitMode |=> modeReg == ($past(hwdata[15:0]) & MODE_MASK))
    else $error("mode write lost");
  a_no_runt: assert property (
    $changed(activeSrc) |-> !masterClk && !$past(masterClk))
    else $error("source changed with clock high");
  a_pend_hold: assert property (
    isPending && !masterClk |=> !masterClk)
    else $error("master clock rose during switch");
  a_int_period: assert property (
    activeSrc == SRC_INT && !isPending && $rose(masterClk)
    |-> ##1 masterClk [*8])
    else $error("master clock high phase too short");
  a_xtal_div: assert property (
    xtalRise && activeSrc == SRC_XTAL && xtalCnt == 2'b11
    |=> xtalDiv != $past(xtalDiv))
    else $error("crystal divider did not toggle");
  a_ext_route: assert property (
    activeSrc == SRC_EXT && reqSrc == SRC_EXT |=> masterClk == $past(extSync[1]))
    else $error("external clock not routed");
  a_pin_drive: assert property (
    activeSrc == SRC_INT_OUT |=> !sharedClkOe_n && sharedClkOut == $past(intClk))
    else $error("oscillator not driven on shared pin");
  a_tick_edge: assert property (
    modulatorTick |-> masterClk && !$past(masterClk))
    else $error("tick without master clock edge");
  a_switch_bound: assert property (
    $changed(reqSrc) && reqSrc != SRC_XTAL |-> ##[0:300] !isPending)
    else $error("clock switch too slow");

  c_to_xtal: cover property (activeSrc == SRC_XTAL && $rose(masterClk));
  c_to_ext: cover property (activeSrc == SRC_EXT && $rose(masterClk));
  c_pin_out: cover property (!sharedClkOe_n);
  c_ref_on: cover property ($rose(refOutEnable));
  c_switch_wait: cover property (isPending && masterClk);

endmodule
`default_nettype wire

// ===== verif/acrs_clk_model.sv
// Crystal and external clock source on the far side of the clock pins
`timescale 1ns/1ps
`default_nettype none
module acrs_clk_model
(
  // Device driver of the shared pin
  input  wire logic sharedClkOut,
  input  wire logic sharedClkOe_n,
  // Pin levels seen by the device
  output logic      crystalIn,
  output logic      sharedClkIn
);
  logic extClk;

  initial
  begin
    crystalIn = 1'b0;
    extClk = 1'b0;
  end
  // Crystal of 16 MHz runs free
  always #31.25 crystalIn = ~crystalIn;
  // Slower than 2 MHz on purpose, so rate scaling shows
  always #500 extClk = ~extClk;
  // The device driver wins the pin while its enable is low
  assign sharedClkIn = sharedClkOe_n ? extClk : sharedClkOut;
endmodule
`default_nettype wire

// ===== verif/adc_clock_and_reference_select_bench.sv
// Self-checking bench of the clock and reference selection block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin \
  n_fail++; $display("BAD %s exp %0h got %0h", nm, ex, got); end end
module adc_clock_and_reference_select_bench
  import acrs_pkg::*;
;
  typedef struct
  {
    logic [31:0] a;
    logic [15:0] w;
    logic [31:0] r;
    int          per;
    logic        oe;
  } acrs_row_t;

  logic        ref_clk;
  logic        rst_n;
  logic        hsel;
  logic [31:0] haddr;
  logic [1:0]  htrans;
  logic        hwrite;
  logic [2:0]  hsize;
  logic [31:0] hwdata;
  wire  logic  hready;
  logic [31:0] hrdata;
  logic        hreadyout;
  logic        hresp;
  logic        crystalIn;
  logic        sharedClkIn;
  logic        sharedClkOut;
  logic        sharedClkOe_n;
  logic        masterClk;
  logic        modulatorTick;
  logic        refOutEnable;
  logic [1:0]  refSelect;
  logic        bufChopMax;
  logic        singleCycle;
  logic [1:0]  ainBufEnable;
  logic [1:0]  refBufEnable;
  logic        bipolar;
  logic        burnoutEnable;
  logic [31:0] rd;
  int          n;
  int          n_fail = 0;
  int          cmp_count = 0;
  acrs_row_t   rows [6];

  // The one slave drives the bus ready
  assign hready = hreadyout;

  acrs_top uut
  (
    .ref_clk(ref_clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .crystalIn(crystalIn), .sharedClkIn(sharedClkIn),
    .sharedClkOut(sharedClkOut), .sharedClkOe_n(sharedClkOe_n),
    .masterClk(masterClk), .modulatorTick(modulatorTick),
    .refOutEnable(refOutEnable), .refSelect(refSelect),
    .bufChopMax(bufChopMax), .singleCycle(singleCycle),
    .ainBufEnable(ainBufEnable), .refBufEnable(refBufEnable),
    .bipolar(bipolar), .burnoutEnable(burnoutEnable)
  );

  acrs_clk_model far_side
  (
    .sharedClkOut(sharedClkOut), .sharedClkOe_n(sharedClkOe_n),
    .crystalIn(crystalIn), .sharedClkIn(sharedClkIn)
  );

  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Waits for ready as long as it takes; only the watchdog ends a hang
  task automatic rdy;
    do
      @(posedge ref_clk);
    while (hready !== 1'b1);
  endtask

  // Entered just after a rising edge; returns at the data phase's end
  task automatic bus(input logic w, input logic [31:0] a,
                     input logic [15:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'h2;
    hwrite <= w;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    rdy();
    q = hrdata;
  endtask

  // Cycles between two ticks, sampled where outputs have settled
  task automatic period(output int p);
    p = 0;
    while (modulatorTick !== 1'b1 && p < 3000)
    begin
      @(negedge ref_clk);
      p++;
    end
    p = 0;
    do
    begin
      @(negedge ref_clk);
      p++;
    end
    while (modulatorTick !== 1'b1 && p < 3000);
  endtask

  initial
  begin
    #200000;
    n_fail++;
    test_done();
  end

  initial
  begin
    rows = '{'{ADDR_MODE, 16'hFFFF, 32'hA77C, 125, 1'b1},
             '{ADDR_MODE, 16'h2000, 32'h2000, 125, 1'b1},
             '{ADDR_MODE, 16'h2004, 32'h2004, 125, 1'b0},
             '{ADDR_MODE, 16'h2008, 32'h2008, 250, 1'b1},
             '{ADDR_SETUP0, 16'hFFFF, 32'h1FF0, 0, 1'b1},
             '{32'h40, 16'hFFFF, 32'h0, 0, 1'b1}};
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    foreach (rows[i])
    begin
      bus(1'b1, rows[i].a, rows[i].w, rd);
      bus(1'b0, rows[i].a, 16'h0, rd);
      `CHK("read", rows[i].r, rd)
      `CHK("hresp", 1'b0, hresp)
      if (rows[i].per > 0)
      begin
        period(n);
        period(n);
        `CHK("period", 1'b1, (n >= rows[i].per - 1 && n <= rows[i].per + 1))
        `CHK("clkOe_n", rows[i].oe, sharedClkOe_n)
        `CHK("mclk", 1'b1, masterClk)
        if (!rows[i].oe)
          `CHK("clkOut", 1'b1, sharedClkOut)
      end
    end
    // Single cycle stays set, and both input buffers go on as a pair
    bus(1'b1, ADDR_MODE, 16'hA000, rd);
    bus(1'b1, ADDR_SETUP0, 16'h0BE0, rd);
    repeat (2) @(negedge ref_clk);
    `CHK("reference_output_pin", 1'b1, refOutEnable)
    `CHK("chopMax", 1'b1, bufChopMax)
    `CHK("refSel", 2'h2, refSelect)
    `CHK("ainBuf", 2'h3, ainBufEnable)
    `CHK("sCyc", 1'b1, singleCycle)
    `CHK("refBuf", 2'h2, refBufEnable)
    `CHK("bipolar", 1'b0, bipolar)
    `CHK("burnout", 1'b1, burnoutEnable)
    // Second reset in mid-run
    @(posedge ref_clk);
    rst_n <= 1'b0;
    @(negedge ref_clk);
    `CHK("mclkRst", 1'b0, masterClk)
    `CHK("oeRst", 1'b1, sharedClkOe_n)
    @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge ref_clk);
    bus(1'b0, ADDR_MODE, 16'h0, rd);
    `CHK("modeRst", {16'h0, MODE_RST}, rd)
    bus(1'b0, ADDR_SETUP0, 16'h0, rd);
    `CHK("setupRst", {16'h0, SETUP0_RST}, rd)
    bus(1'b0, ADDR_STATUS, 16'h0, rd);
    `CHK("source", SRC_INT, rd[1:0])
    @(negedge ref_clk);
    `CHK("refOutRst", 1'b0, refOutEnable)
    `CHK("refSelRst", REFSEL_EXT, refSelect)
    `CHK("bipolRst", 1'b1, bipolar)
    test_done();
  end
endmodule
`undef CHK
`default_nettype wire
